//--- verilog/host_reg_bank_regs.vh
// Offsets, field positions, reset values and constants of the host register bank
`ifndef HOST_REG_BANK_REGS_VH
`define HOST_REG_BANK_REGS_VH

`define ADDR_W 7
`define OFF_CMD_IN 7'h00
`define OFF_WAKE_OUT 7'h01
`define OFF_NWAKE_OUT 7'h02
`define OFF_STDBG_OUT 7'h03
`define OFF_RSVD_GAP 7'h04
`define OFF_CORE_CTRL 7'h05
`define OFF_PORT_ACT 7'h06
`define OFF_IRQ_CTRL 7'h07
`define OFF_SCRATCH_LO 7'h08
`define OFF_SCRATCH_HI 7'h13
`define OFF_RST_REQ 7'h14
`define OFF_EVT_REQ 7'h15
`define OFF_PROTO_CTRL 7'h16
`define OFF_PWR_STATE 7'h17
`define OFF_CRC_B0 7'h18
`define OFF_CRC_B3 7'h1B

`define RST_CTRL 8'h00
`define RST_SCRATCH 96'h0
`define CRC_SEED 32'hFFFFFFFF

`define EVT_REQ_BIT 0
`define ST_POWER_BIT 0
`define ST_CMD_BUSY_BIT 1
`define ST_WAKE_PEND_BIT 2
`define ST_NWAKE_PEND_BIT 3
`define ST_STDBG_PEND_BIT 4
`define ST_I2C_BIT 5

`define CH_CMD 2'd0

`endif

//--- verilog/host_reg_bank.v
// Host-facing register bank: channels, control, scratch, status and channel CRC
//
// Operation
// - Every host to core exchange passes only through this register bank.
// - Read-write registers accept host reads and host writes.
// - Read-only registers return values; host writes to them are ignored.
// - One register map serves both SPI and I2C host protocols.
// - Offset 0x00 is write-only command input channel to the core.
// - Offset 0x01 reads bytes from the wake-up FIFO channel.
// - Offset 0x02 reads bytes from the non-wake-up FIFO channel.
// - Offset 0x03 reads status and debug packet bytes.
// - Offset 0x05 is read-write core behaviour control.
// - Offset 0x06 is read-write host interface action control.
// - Offset 0x07 is read-write interrupt output control and masks.
// - Offsets 0x08-0x13 are host read-write scratch, core read-only.
// - Offset 0x14 is read-write core reset request.
// - Offset 0x15 is read-write timestamp event request.
// - Offset 0x16 is read-write SPI mode and I2C watchdog control.
// - Offset 0x17 reads power, protocol and channel state.
// - Offsets 0x18-0x1B read the CRC of the last used channel.
// - Writing one to event request bit zero pulses core event interrupt.
// - Command packets are two-byte code, two-byte length, optional parameters.
// - Output channels return zero when no data is pending.
`timescale 1ns/1ps
`default_nettype none
`include "host_reg_bank_regs.vh"

module host_reg_bank #(
  parameter [31:0] CRC_POLY = 32'hEDB88320
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Byte access from the SPI or I2C slave front end
  input wire [`ADDR_W-1:0] host_addr,
  input wire host_wr,
  input wire host_rd,
  input wire [7:0] host_wdata,
  output reg [7:0] host_rdata,
  output reg host_rvalid,
  // Front end and power state
  input wire host_is_i2c,
  input wire core_powered,
  // Command channel towards the core DMA
  output reg [7:0] cmd_data,
  output reg cmd_valid,
  input wire cmd_ready,
  output reg cmd_overflow,
  // Output channels from the core DMA, wake-up in the low byte
  input wire [23:0] out_data,
  input wire [2:0] out_valid,
  output reg [2:0] out_pop,
  output reg [2:0] out_underflow,
  // Control values seen by the core
  output reg [7:0] core_ctrl,
  output reg [7:0] port_act_ctrl,
  output reg [7:0] irq_ctrl,
  output reg [95:0] scratch,
  output reg [7:0] rst_req,
  output reg [7:0] evt_req,
  output reg [7:0] proto_ctrl,
  output reg host_ev_irq
);

  reg [31:0] crc_q;
  reg [31:0] crc_d;
  reg [1:0] last_ch_q;
  reg [1:0] crc_ch;
  reg [7:0] crc_byte_in;
  reg crc_en;
  reg [7:0] rd_mux;
  reg [7:0] status_d;
  reg [2:0] pop_d;
  reg [2:0] uflow_d;
  reg [3:0] scr_idx;
  // Reset image of the scratch bytes, sliced per byte below
  wire [95:0] scratch_rst = `RST_SCRATCH;

  wire wr_cmd = host_wr && (host_addr == `OFF_CMD_IN);
  wire in_scratch = (host_addr >= `OFF_SCRATCH_LO) && (host_addr <= `OFF_SCRATCH_HI);
  wire in_crc = (host_addr >= `OFF_CRC_B0) && (host_addr <= `OFF_CRC_B3);
  // Only read-write offsets and the command input decode to a write strobe, so read-only ones never change
  wire wr_core_ctrl = host_wr && (host_addr == `OFF_CORE_CTRL);
  wire wr_port_act = host_wr && (host_addr == `OFF_PORT_ACT);
  wire wr_irq_ctrl = host_wr && (host_addr == `OFF_IRQ_CTRL);
  wire wr_rst_req = host_wr && (host_addr == `OFF_RST_REQ);
  wire wr_evt_req = host_wr && (host_addr == `OFF_EVT_REQ);
  wire wr_proto_ctrl = host_wr && (host_addr == `OFF_PROTO_CTRL);

  // Byte-wise reflected CRC; the polynomial is a parameter
  function [31:0] crc_step;
    input [31:0] c;
    input [7:0] d;
    integer i;
    reg [31:0] t;
    begin
      t = c;
      for (i = 0; i < 8; i = i + 1) begin
        if (t[0] ^ d[i]) begin
          t = (t >> 1) ^ CRC_POLY;
        end else begin
          t = t >> 1;
        end
      end
      crc_step = t;
    end
  endfunction

  // Output channel pops: an empty channel answers zero and flags underflow
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_out
      wire rd_hit = host_rd && (host_addr == (`OFF_WAKE_OUT + g));
      always @* begin
        pop_d[g] = 1'b0;
        uflow_d[g] = 1'b0;
        if (rd_hit) begin
          pop_d[g] = out_valid[g];
          uflow_d[g] = ~out_valid[g];
        end
      end
    end
  endgenerate

  // Scratch bytes, low byte at the lowest offset
  generate
    for (g = 0; g < 12; g = g + 1) begin : g_scr
      wire wr_hit = host_wr && (host_addr == (`OFF_SCRATCH_LO + g));
      always @(posedge clk) begin
        if (srst) begin
          scratch[8*g +: 8] <= scratch_rst[8*g +: 8];
        end else if (wr_hit) begin
          scratch[8*g +: 8] <= host_wdata;
        end
      end
    end
  endgenerate

  // Host status: power, protocol and channel activity
  // Bits 6 and 7 are unused and read as zero
  always @* begin
    status_d = 8'h00;
    status_d[`ST_POWER_BIT] = core_powered;
    status_d[`ST_CMD_BUSY_BIT] = cmd_valid;
    status_d[`ST_WAKE_PEND_BIT] = out_valid[0];
    status_d[`ST_NWAKE_PEND_BIT] = out_valid[1];
    status_d[`ST_STDBG_PEND_BIT] = out_valid[2];
    status_d[`ST_I2C_BIT] = host_is_i2c;
  end

  // Read mux; the command channel and reserved gap read as zero
  always @* begin
    scr_idx = host_addr[3:0] - 4'h8;
    rd_mux = 8'h00;
    if (in_scratch) begin
      // Scratch byte k sits at offset 0x08 plus k
      rd_mux = scratch[8*scr_idx +: 8];
    end else if (in_crc) begin
      // CRC byte n sits at offset 0x18 plus n
      rd_mux = crc_q[8*host_addr[1:0] +: 8];
    end else begin
      // Channel, control and status bytes: an empty channel reads zero
      case (host_addr)
        `OFF_WAKE_OUT: begin
          rd_mux = out_valid[0] ? out_data[7:0] : 8'h00;
        end
        `OFF_NWAKE_OUT: begin
          rd_mux = out_valid[1] ? out_data[15:8] : 8'h00;
        end
        `OFF_STDBG_OUT: begin
          rd_mux = out_valid[2] ? out_data[23:16] : 8'h00;
        end
        `OFF_CORE_CTRL: begin
          rd_mux = core_ctrl;
        end
        `OFF_PORT_ACT: begin
          rd_mux = port_act_ctrl;
        end
        `OFF_IRQ_CTRL: begin
          rd_mux = irq_ctrl;
        end
        `OFF_RST_REQ: begin
          rd_mux = rst_req;
        end
        `OFF_EVT_REQ: begin
          rd_mux = evt_req;
        end
        `OFF_PROTO_CTRL: begin
          rd_mux = proto_ctrl;
        end
        `OFF_PWR_STATE: begin
          rd_mux = status_d;
        end
        default: begin
          rd_mux = 8'h00;
        end
      endcase
    end
  end

  // CRC source: a command write takes precedence over a pop in the same cycle
  always @* begin
    crc_en = 1'b0;
    crc_ch = `CH_CMD;
    crc_byte_in = host_wdata;
    if (wr_cmd) begin
      crc_en = 1'b1;
    end else if (pop_d[0]) begin
      crc_en = 1'b1;
      crc_ch = 2'd1;
      crc_byte_in = out_data[7:0];
    end else if (pop_d[1]) begin
      crc_en = 1'b1;
      crc_ch = 2'd2;
      crc_byte_in = out_data[15:8];
    end else if (pop_d[2]) begin
      crc_en = 1'b1;
      crc_ch = 2'd3;
      crc_byte_in = out_data[23:16];
    end
  end

  // Switching channels restarts the CRC from the seed
  always @* begin
    crc_d = crc_q;
    if (crc_en) begin
      if (crc_ch != last_ch_q) begin
        crc_d = crc_step(`CRC_SEED, crc_byte_in);
      end else begin
        crc_d = crc_step(crc_q, crc_byte_in);
      end
    end
  end

  // A channel switch restarts from the seed so the host sees one transfer's CRC
  always @(posedge clk) begin
    if (srst) begin
      crc_q <= `CRC_SEED;
    end else if (crc_en) begin
      crc_q <= crc_d;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      last_ch_q <= `CH_CMD;
    end else if (crc_en) begin
      last_ch_q <= crc_ch;
    end
  end

  // Host read answer one cycle after the strobe; data is zero outside the answer cycle
  always @(posedge clk) begin
    if (srst) begin
      host_rdata <= 8'h00;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= host_rd;
      host_rdata <= host_rd ? rd_mux : 8'h00;
    end
  end

  // Channel advance and empty-read pulses towards the core DMA
  always @(posedge clk) begin
    if (srst) begin
      out_pop <= 3'b000;
    end else begin
      out_pop <= pop_d;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      out_underflow <= 3'b000;
    end else begin
      out_underflow <= uflow_d;
    end
  end

  // Command bytes go straight to the core; framing is left to its DMA
  always @(posedge clk) begin
    if (srst) begin
      cmd_data <= 8'h00;
    end else if (wr_cmd) begin
      cmd_data <= host_wdata;
    end
  end

  // A new write wins over a claim in the same cycle, so no byte vanishes unseen
  always @(posedge clk) begin
    if (srst) begin
      cmd_valid <= 1'b0;
    end else if (wr_cmd) begin
      cmd_valid <= 1'b1;
    end else if (cmd_ready) begin
      cmd_valid <= 1'b0;
    end
  end

  // No buffer here: a byte arriving while one is unclaimed replaces it
  always @(posedge clk) begin
    if (srst) begin
      cmd_overflow <= 1'b0;
    end else begin
      cmd_overflow <= wr_cmd && cmd_valid && !cmd_ready;
    end
  end

  // Host read-write control registers, one per offset
  always @(posedge clk) begin
    if (srst) begin
      core_ctrl <= `RST_CTRL;
    end else if (wr_core_ctrl) begin
      core_ctrl <= host_wdata;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      port_act_ctrl <= `RST_CTRL;
    end else if (wr_port_act) begin
      port_act_ctrl <= host_wdata;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      irq_ctrl <= `RST_CTRL;
    end else if (wr_irq_ctrl) begin
      irq_ctrl <= host_wdata;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      rst_req <= `RST_CTRL;
    end else if (wr_rst_req) begin
      rst_req <= host_wdata;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      evt_req <= `RST_CTRL;
    end else if (wr_evt_req) begin
      evt_req <= host_wdata;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      proto_ctrl <= `RST_CTRL;
    end else if (wr_proto_ctrl) begin
      proto_ctrl <= host_wdata;
    end
  end

  // Event request value is kept as written; the core sees a one-cycle pulse
  always @(posedge clk) begin
    if (srst) begin
      host_ev_irq <= 1'b0;
    end else begin
      host_ev_irq <= wr_evt_req && host_wdata[`EVT_REQ_BIT];
    end
  end

endmodule // host_reg_bank
`default_nettype wire

//--- dv/host_reg_bank_assertions.sv
// Port-level checks of the host register bank
`timescale 1ns/1ps
`default_nettype none
module host_reg_bank_chk (
  // Clock, reset, host bus
  input wire logic clk, srst, host_wr, host_rd, host_rvalid, host_is_i2c, core_powered,
  input wire logic [6:0] host_addr,
  input wire logic [7:0] host_wdata, host_rdata, cmd_data, core_ctrl, evt_req,
  // Core side
  input wire logic cmd_valid, cmd_ready, cmd_overflow, host_ev_irq,
  input wire logic [23:0] out_data,
  input wire logic [2:0] out_valid, out_pop, out_underflow
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_rd; host_rd |=> host_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read unanswered");
  property p_evt; host_wr && host_addr == 7'h15 && host_wdata[0] |=> host_ev_irq; endproperty
  a_evt: assert property (p_evt) else $error("event irq missing");
  property p_irq; host_ev_irq |-> $past(host_wr) && $past(host_addr) == 7'h15; endproperty
  a_irq: assert property (p_irq) else $error("stray event irq");
  property p_cmd; host_wr && host_addr == 7'h00 |=> cmd_valid && cmd_data == $past(host_wdata);
  endproperty
  a_cmd: assert property (p_cmd) else $error("command byte lost");
  property p_ovf; host_wr && host_addr == 7'h00 && cmd_valid && !cmd_ready |=> cmd_overflow;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow missing");
  property p_pop; host_rd && host_addr == 7'h01 && out_valid[0]
    |=> out_pop[0] && host_rdata == $past(out_data[7:0]); endproperty
  a_pop: assert property (p_pop) else $error("wake byte wrong");
  property p_empty; host_rd && host_addr == 7'h03 && !out_valid[2]
    |=> out_underflow[2] && !out_pop[2] && host_rdata == 8'h00; endproperty
  a_empty: assert property (p_empty) else $error("empty read wrong");
  property p_ctrl; host_wr && host_addr == 7'h05 |=> core_ctrl == $past(host_wdata); endproperty
  a_ctrl: assert property (p_ctrl) else $error("control not stored");
  property p_stat; host_rd && host_addr == 7'h17 |=> host_rdata == {2'b00, $past(host_is_i2c),
    $past(out_valid), $past(cmd_valid), $past(core_powered)}; endproperty
  a_stat: assert property (p_stat) else $error("status wrong");
  cover property (host_ev_irq);
  cover property (cmd_overflow);
  cover property (|out_underflow);
endmodule // host_reg_bank_chk
bind host_reg_bank host_reg_bank_chk u_chk (.*);
`default_nettype wire

//--- dv/core_model.sv
// Core-side model: command sink and three two-byte output streams
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic clk, srst, slow,
  input wire logic [2:0] out_pop,
  output logic cmd_ready,
  output logic [23:0] out_data,
  output logic [2:0] out_valid
);
  logic [1:0] cnt_q [3];
  assign cmd_ready = !slow;
  for (genvar i = 0; i < 3; i++) begin : g_ch
    // Two size bytes per stream, then empty; idle bus shows FF, not zero
    assign out_valid[i] = cnt_q[i] < 2'd2;
    assign out_data[8*i+:8] = out_valid[i] ? 8'(8'h11 * (i + 1)) + {6'h00, cnt_q[i]} : 8'hFF;
    always @(posedge clk) begin
      if (srst) cnt_q[i] <= 2'd0;
      else if (out_pop[i]) cnt_q[i] <= cnt_q[i] + 2'd1;
    end
  end
endmodule // core_model
`default_nettype wire

//--- dv/test_host_reg_bank.sv
// Self-checking bench of the host register bank
`timescale 1ns/1ps
`default_nettype none
module test_host_reg_bank;
  logic clk, srst, host_wr, host_rd, host_is_i2c, core_powered, cmd_ready, cmd_valid;
  logic cmd_overflow, host_rvalid, host_ev_irq, slow;
  logic [6:0] host_addr;
  logic [7:0] host_wdata, host_rdata, cmd_data, core_ctrl, port_act_ctrl, irq_ctrl, v;
  logic [7:0] rst_req, evt_req, proto_ctrl;
  logic [95:0] scratch;
  logic [23:0] out_data;
  logic [2:0] out_valid, out_pop, out_underflow;
  logic [31:0] crc;
  int n_mismatch, n_tests;
  host_reg_bank dut (.*);
  core_model core (.clk, .srst, .slow, .out_pop, .cmd_ready, .out_data, .out_valid);
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %h, expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] crc_b(input logic [31:0] c, input logic [7:0] d);
    c = c ^ {24'h0, d};
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    return c;
  endfunction
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    host_wr <= 1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge clk);
    host_wr <= 0;
    if (a == 7'h00) crc = crc_b(crc, d);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    host_rd <= 1;
    host_addr <= a;
    @(posedge clk);
    host_rd <= 0;
    #1 d = host_rdata;
  endtask
  task automatic crc_chk;
    for (int i = 0; i < 4; i++) begin
      rd(7'h18 + 7'(i), v);
      chk(v, crc[8*i+:8]);
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    complete_run;
  end
  initial begin
    {srst, core_powered} = 2'b11;
    {host_wr, host_rd, host_is_i2c, slow} = 4'h0;
    {host_addr, host_wdata} = 15'h0;
    crc = 32'hFFFFFFFF;
    repeat (8) @(posedge clk);
    srst <= 0;
    crc_chk;
    // Read-write map except the event request at 0x15, each byte on its own address
    for (int a = 5; a < 23; a++) if (a != 21) wr(7'(a), 8'(a + 64));
    for (int a = 1; a < 28; a++) if (a < 5 || a > 22) wr(7'(a), 8'hFF);
    for (int a = 5; a < 23; a++) if (a != 21) begin
      rd(7'(a), v);
      chk(v, a + 64);
    end
    chk({scratch[95:88], core_ctrl, irq_ctrl, rst_req}, 32'h53454754);
    chk({scratch[7:0], port_act_ctrl, proto_ctrl}, 24'h484656);
    rd(7'h04, v);
    chk(v, 0);
    rd(7'h00, v);
    chk(v, 0);
    for (int m = 0; m < 2; m++) begin
      @(posedge clk) host_is_i2c <= m[0];
      rd(7'h17, v);
      chk(v, {2'b00, m[0], 5'b11101});
    end
    wr(7'h15, 8'h01);
    #1 chk(host_ev_irq, 1);
    wr(7'h15, 8'h02);
    #1 chk(host_ev_irq, 0);
    rd(7'h15, v);
    chk(v, 8'h02);
    chk(evt_req, 8'h02);
    // Stalled core: second byte overwrites the first
    @(posedge clk) slow <= 1;
    wr(7'h00, 8'h01);
    wr(7'h00, 8'h00);
    #1 chk({cmd_overflow, cmd_data}, 9'h100);
    @(posedge clk) slow <= 0;
    wr(7'h00, 8'h02);
    wr(7'h00, 8'h00);
    repeat (2) @(posedge clk);
    chk(cmd_valid, 0);
    crc_chk;
    for (int ch = 1; ch < 4; ch++) begin
      crc = 32'hFFFFFFFF;
      for (int n = 0; n < 3; n++) begin
        rd(7'(ch), v);
        chk(v, n < 2 ? 17 * ch + n : 0);
        if (n < 2) crc = crc_b(crc, 8'(17 * ch + n));
      end
      crc_chk;
    end
    complete_run;
  end
endmodule // test_host_reg_bank
`default_nettype wire
